// File: logic/pfm_pkg.sv
package pfm_pkg;

  // ----------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------
  localparam int          NUM_PINS      = 7;
  localparam int          SEL_W         = 5;
  localparam int          REG_W         = 8;
  localparam int          ADDR_W        = 12;
  localparam int          IDX_LSB       = 2;
  localparam int          IDX_W         = 3;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [4:0]  SEL_HIZ       = 5'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ----------------------------------------------------------------
  // Select codes
  // ----------------------------------------------------------------
  localparam logic [4:0]  SEL_TIMER_A   = 5'h01;
  localparam logic [4:0]  SEL_TIMER_B   = 5'h02;
  localparam logic [4:0]  SEL_TIMER_C   = 5'h03;
  localparam logic [4:0]  SEL_TIMER_D   = 5'h04;
  localparam logic [4:0]  SEL_TIMER8    = 5'h05;
  localparam logic [4:0]  SEL_CLK_POE   = 5'h07;
  localparam logic [4:0]  SEL_SERIAL_A  = 5'h0A;
  localparam logic [4:0]  SEL_SERIAL_B  = 5'h0B;
  localparam logic [4:0]  SEL_SPI       = 5'h0D;
  localparam logic [4:0]  SEL_TOUCH     = 5'h19;

  // ----------------------------------------------------------------
  // Peripheral function indices
  // ----------------------------------------------------------------
  localparam int          NUM_FUNCS     = 34;
  localparam int          FUNC_W        = 6;
  localparam logic [5:0]  FN_TIMER4_CAPTURE_IO_A      = 6'h00;
  localparam logic [5:0]  FN_CLOCK_ACCURACY_REFERENCE = 6'h01;
  localparam logic [5:0]  FN_SPI_SLAVE_SELECT_1       = 6'h02;
  localparam logic [5:0]  FN_TOUCH_SENSE_32           = 6'h03;
  localparam logic [5:0]  FN_TIMER0_IO_B              = 6'h04;
  localparam logic [5:0]  FN_TIMER_EXT_CLK_C          = 6'h05;
  localparam logic [5:0]  FN_TIMER3_IO_B              = 6'h06;
  localparam logic [5:0]  FN_SERIAL5_CLOCK            = 6'h07;
  localparam logic [5:0]  FN_SPI_SLAVE_SELECT_2       = 6'h08;
  localparam logic [5:0]  FN_TOUCH_SENSE_31           = 6'h09;
  localparam logic [5:0]  FN_SERIAL5_RECEIVE_GROUP    = 6'h0A;
  localparam logic [5:0]  FN_SPI_SLAVE_SELECT_3       = 6'h0B;
  localparam logic [5:0]  FN_TOUCH_SENSE_30           = 6'h0C;
  localparam logic [5:0]  FN_TIMER0_IO_D              = 6'h0D;
  localparam logic [5:0]  FN_TIMER_EXT_CLK_D          = 6'h0E;
  localparam logic [5:0]  FN_TIMER4_IO_D              = 6'h0F;
  localparam logic [5:0]  FN_TIMER5_CAPTURE_V         = 6'h10;
  localparam logic [5:0]  FN_TOUCH_SENSE_29           = 6'h11;
  localparam logic [5:0]  FN_TIMER5_CAPTURE_U         = 6'h12;
  localparam logic [5:0]  FN_TIMER_EXT_CLK_A          = 6'h13;
  localparam logic [5:0]  FN_TIMER4_IO_C              = 6'h14;
  localparam logic [5:0]  FN_TIMER8_RESET_IN_0        = 6'h15;
  localparam logic [5:0]  FN_SERIAL5_TRANSMIT_GROUP   = 6'h16;
  localparam logic [5:0]  FN_SPI_SLAVE_SELECT_0       = 6'h17;
  localparam logic [5:0]  FN_TOUCH_SENSE_28           = 6'h18;
  localparam logic [5:0]  FN_SPI_CLOCK_LINE           = 6'h19;
  localparam logic [5:0]  FN_TOUCH_SENSE_27           = 6'h1A;
  localparam logic [5:0]  FN_TIMER_EXT_CLK_B          = 6'h1B;
  localparam logic [5:0]  FN_TIMER3_IO_D              = 6'h1C;
  localparam logic [5:0]  FN_TIMER8_CLOCK_IN_3        = 6'h1D;
  localparam logic [5:0]  FN_PORT_OUTPUT_DISABLE_IN_2 = 6'h1E;
  localparam logic [5:0]  FN_SERIAL5_FLOW_GROUP       = 6'h1F;
  localparam logic [5:0]  FN_SPI_MASTER_OUT_LINE      = 6'h20;
  localparam logic [5:0]  FN_TOUCH_SENSE_26           = 6'h21;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       hit;
    logic [5:0] func;
  } pfm_route_s;

endpackage : pfm_pkg

// File: logic/pfm_port_a_mux.sv
// Notes on behaviour
// RULE_01: Each pin has its own control register; zero select leaves pin Hi-Z.
// RULE_02: Control registers exist only for pins 0 to 6; no pin 7 register.
// RULE_03: Pin 0 routes timer4 io a, clock reference, slave select 1, touch.
// RULE_04: Pin 1 codes route timer0 io b, ext clock c, timer3 io b, etc.
// RULE_05: Pin 2 codes route serial5 receive, slave select 3, touch 30.
// RULE_06: Pin 3 codes route timer0 io d, ext clock d, timer4 io d, etc.
// RULE_07: Pin 4 codes route timer5 u, ext clock a, timer4 io c, etc.
// RULE_08: Pin 5 codes route SPI clock line and touch 27.
// RULE_09: Pin 6 codes route timer5 v, ext clock b, timer3 io d, etc.
// RULE_10: Unlisted codes behave like zero; select field resets to zero.
`timescale 1ns/1ps

module pfm_port_a_mux
  import pfm_pkg::*;
#(
  parameter int NPINS  = NUM_PINS,
  parameter int NFUNCS = NUM_FUNCS
) (
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [NFUNCS-1:0]   periph_out,
  input  wire logic [NFUNCS-1:0]   periph_oe,
  output logic      [NFUNCS-1:0]   periph_in,
  input  wire logic [NPINS-1:0]    pin_in,
  output logic      [NPINS-1:0]    pin_out,
  output logic      [NPINS-1:0]    pin_oe
);

  // ----------------------------------------------------------------
  // Select decode
  // ----------------------------------------------------------------
  // One table for all pins keeps the per-pin logic a plain generate.
  function automatic pfm_route_s decode_sel(
    input logic [IDX_W-1:0] pin,
    input logic [SEL_W-1:0] code
  );
    pfm_route_s r;
    r.hit  = 1'b1;
    r.func = FN_TIMER4_CAPTURE_IO_A;
    case (pin)
      // RULE_03: pin 0 table.
      3'h0: begin
        case (code)
          SEL_TIMER_A:  r.func = FN_TIMER4_CAPTURE_IO_A;
          SEL_CLK_POE:  r.func = FN_CLOCK_ACCURACY_REFERENCE;
          SEL_SPI:      r.func = FN_SPI_SLAVE_SELECT_1;
          SEL_TOUCH:    r.func = FN_TOUCH_SENSE_32;
          default:      r.hit  = 1'b0;
        endcase
      end
      // RULE_04: pin 1 table.
      3'h1: begin
        case (code)
          SEL_TIMER_A:  r.func = FN_TIMER0_IO_B;
          SEL_TIMER_B:  r.func = FN_TIMER_EXT_CLK_C;
          SEL_TIMER_C:  r.func = FN_TIMER3_IO_B;
          SEL_SERIAL_A: r.func = FN_SERIAL5_CLOCK;
          SEL_SPI:      r.func = FN_SPI_SLAVE_SELECT_2;
          SEL_TOUCH:    r.func = FN_TOUCH_SENSE_31;
          default:      r.hit  = 1'b0;
        endcase
      end
      // RULE_05: pin 2 table.
      3'h2: begin
        case (code)
          SEL_SERIAL_A: r.func = FN_SERIAL5_RECEIVE_GROUP;
          SEL_SPI:      r.func = FN_SPI_SLAVE_SELECT_3;
          SEL_TOUCH:    r.func = FN_TOUCH_SENSE_30;
          default:      r.hit  = 1'b0;
        endcase
      end
      // RULE_06: pin 3 table.
      3'h3: begin
        case (code)
          SEL_TIMER_A:  r.func = FN_TIMER0_IO_D;
          SEL_TIMER_B:  r.func = FN_TIMER_EXT_CLK_D;
          SEL_TIMER_C:  r.func = FN_TIMER4_IO_D;
          SEL_TIMER_D:  r.func = FN_TIMER5_CAPTURE_V;
          SEL_SERIAL_A: r.func = FN_SERIAL5_RECEIVE_GROUP;
          SEL_TOUCH:    r.func = FN_TOUCH_SENSE_29;
          default:      r.hit  = 1'b0;
        endcase
      end
      // RULE_07: pin 4 table.
      3'h4: begin
        case (code)
          SEL_TIMER_A:  r.func = FN_TIMER5_CAPTURE_U;
          SEL_TIMER_B:  r.func = FN_TIMER_EXT_CLK_A;
          SEL_TIMER_C:  r.func = FN_TIMER4_IO_C;
          SEL_TIMER8:   r.func = FN_TIMER8_RESET_IN_0;
          SEL_SERIAL_A: r.func = FN_SERIAL5_TRANSMIT_GROUP;
          SEL_SPI:      r.func = FN_SPI_SLAVE_SELECT_0;
          SEL_TOUCH:    r.func = FN_TOUCH_SENSE_28;
          default:      r.hit  = 1'b0;
        endcase
      end
      // RULE_08: pin 5 table.
      3'h5: begin
        case (code)
          SEL_SPI:      r.func = FN_SPI_CLOCK_LINE;
          SEL_TOUCH:    r.func = FN_TOUCH_SENSE_27;
          default:      r.hit  = 1'b0;
        endcase
      end
      // RULE_09: pin 6 table.
      3'h6: begin
        case (code)
          SEL_TIMER_A:  r.func = FN_TIMER5_CAPTURE_V;
          SEL_TIMER_B:  r.func = FN_TIMER_EXT_CLK_B;
          SEL_TIMER_C:  r.func = FN_TIMER3_IO_D;
          SEL_TIMER8:   r.func = FN_TIMER8_CLOCK_IN_3;
          SEL_CLK_POE:  r.func = FN_PORT_OUTPUT_DISABLE_IN_2;
          SEL_SERIAL_B: r.func = FN_SERIAL5_FLOW_GROUP;
          SEL_SPI:      r.func = FN_SPI_MASTER_OUT_LINE;
          SEL_TOUCH:    r.func = FN_TOUCH_SENSE_26;
          default:      r.hit  = 1'b0;
        endcase
      end
      // RULE_02: other pin numbers float.
      default: r.hit = 1'b0;
    endcase
    return r;
  endfunction : decode_sel

  // ----------------------------------------------------------------
  // Register bus state
  // ----------------------------------------------------------------
  logic [SEL_W-1:0]  sel_r [NPINS];
  logic              aw_held_r;
  logic              w_held_r;
  logic              aw_held_nxt;
  logic              w_held_nxt;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0]        wbyte_r;
  logic              wstrb0_r;
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic              rvalid_nxt;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  logic              do_write;
  logic              ar_take;
  logic              w_mapped;
  logic              r_mapped;
  logic [IDX_W-1:0]  w_idx;
  logic [IDX_W-1:0]  r_idx;

  // A word is mapped only below the pin count and with no high bits.
  // RULE_02: no pin 7 slot.
  assign w_idx    = awaddr_r[IDX_LSB +: IDX_W];
  assign r_idx    = s_axi_araddr[IDX_LSB +: IDX_W];
  assign w_mapped = (awaddr_r[ADDR_W-1:IDX_LSB+IDX_W] == '0) &&
                    (int'(w_idx) < NPINS);
  assign r_mapped = (s_axi_araddr[ADDR_W-1:IDX_LSB+IDX_W] == '0) &&
                    (int'(r_idx) < NPINS);

  // Write fires once both halves are held and no response is pending.
  assign do_write    = aw_held_r && w_held_r && !bvalid_r;
  assign aw_held_nxt = do_write ? 1'b0 :
                       (aw_held_r | (s_axi_awvalid & awready_r));
  assign w_held_nxt  = do_write ? 1'b0 :
                       (w_held_r | (s_axi_wvalid & wready_r));
  assign ar_take     = s_axi_arvalid && arready_r;
  assign rvalid_nxt  = ar_take | (rvalid_r & ~s_axi_rready);

  // Write address capture; ready drops while an address is held.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_r <= 1'b0;
      awready_r <= 1'b0;
      awaddr_r  <= '0;
    end else begin
      aw_held_r <= aw_held_nxt;
      awready_r <= ~aw_held_nxt;
      if (s_axi_awvalid && awready_r) begin
        awaddr_r <= s_axi_awaddr;
      end
    end
  end

  // Write data capture; only the low byte lane carries a field.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      w_held_r <= 1'b0;
      wready_r <= 1'b0;
      wbyte_r  <= '0;
      wstrb0_r <= 1'b0;
    end else begin
      w_held_r <= w_held_nxt;
      wready_r <= ~w_held_nxt;
      if (s_axi_wvalid && wready_r) begin
        wbyte_r  <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end
    end
  end

  // Write response; unmapped words answer with a slave error.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // RULE_01: per-pin select field.
  // RULE_10: reset to Hi-Z code.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NPINS; i++) begin
        sel_r[i] <= CTRL_RESET[SEL_W-1:0];
      end
    end else if (do_write && w_mapped && wstrb0_r) begin
      sel_r[w_idx] <= wbyte_r[SEL_W-1:0];
    end
  end

  // Read path; the unused upper control bits read as zero.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else begin
      rvalid_r  <= rvalid_nxt;
      arready_r <= ~rvalid_nxt;
      if (ar_take) begin
        rdata_r <= '0;
        rresp_r <= r_mapped ? RESP_OKAY : RESP_SLVERR;
        if (r_mapped) begin
          rdata_r[SEL_W-1:0] <= sel_r[r_idx];
        end
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // ----------------------------------------------------------------
  // Pin multiplexer
  // ----------------------------------------------------------------
  pfm_route_s        route    [NPINS];
  logic [NPINS-1:0]  pin_out_r;
  logic [NPINS-1:0]  pin_oe_r;
  logic [NPINS-1:0]  pin_filt_r;
  logic [NFUNCS-1:0] periph_in_r;
  logic [NFUNCS-1:0] periph_in_nxt;

  genvar p;
  generate
    for (p = 0; p < NPINS; p++) begin : g_pin
      logic [2:0] sync_r;

      assign route[p] = decode_sel(IDX_W'(p), sel_r[p]);

      // RULE_01: unselected pin floats.
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          pin_out_r[p] <= 1'b0;
          pin_oe_r[p]  <= 1'b0;
        end else if (route[p].hit) begin
          pin_out_r[p] <= periph_out[route[p].func];
          pin_oe_r[p]  <= periph_oe[route[p].func];
        end else begin
          pin_out_r[p] <= 1'b0;
          pin_oe_r[p]  <= 1'b0;
        end
      end

      // Three stages; a change counts only when stages two and three
      // agree, which also rejects a single-cycle glitch.
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          sync_r        <= '0;
          pin_filt_r[p] <= 1'b0;
        end else begin
          sync_r <= {sync_r[1:0], pin_in[p]};
          if (sync_r[1] == sync_r[2]) begin
            pin_filt_r[p] <= sync_r[2];
          end
        end
      end
    end
  endgenerate

  // Fan filtered pin levels back to the selected functions. Two pins
  // may pick the same receive function; their levels are ORed.
  always_comb begin
    periph_in_nxt = '0;
    for (int i = 0; i < NPINS; i++) begin
      if (route[i].hit) begin
        periph_in_nxt[route[i].func] = periph_in_nxt[route[i].func] |
                                       pin_filt_r[i];
      end
    end
  end

  // Registered so that every output leaves straight from a flop.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      periph_in_r <= '0;
    end else begin
      periph_in_r <= periph_in_nxt;
    end
  end

  assign pin_out   = pin_out_r;
  assign pin_oe    = pin_oe_r;
  assign periph_in = periph_in_r;

endmodule : pfm_port_a_mux

// File: bench/pfm_mux_monitor.sv
`timescale 1ns/1ps

module pfm_mux_monitor
  import pfm_pkg::*;
#(
  parameter int NPINS  = NUM_PINS,
  parameter int NFUNCS = NUM_FUNCS
) (
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic [NFUNCS-1:0] periph_oe,
  input wire logic [NPINS-1:0]  pin_oe,
  input wire logic [NPINS-1:0]  pin_out
);
  logic [ADDR_W-1:0] aw_r;
  logic [ADDR_W-1:0] ar_r;
  logic [SEL_W-1:0]  wd_r;
  logic              ws_r;
  logic              bv_r;
  logic [SEL_W-1:0]  sel_r [NPINS];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // ----------
  // Shadow of the select fields
  // ----------
  // Request fields are held so that each answer can be tied to its cause.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_r <= '0;
      ar_r <= '0;
      wd_r <= '0;
      ws_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) ar_r <= s_axi_araddr;
      if (s_axi_wvalid && s_axi_wready) begin
        wd_r <= s_axi_wdata[SEL_W-1:0];
        ws_r <= s_axi_wstrb[0];
      end
    end
  end

  // The shadow only follows accepted writes, so a refused one leaves it.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bv_r <= 1'b0;
      for (int i = 0; i < NPINS; i++) sel_r[i] <= SEL_HIZ;
    end else begin
      bv_r <= s_axi_bvalid;
      if (s_axi_bvalid && !bv_r && s_axi_bresp == RESP_OKAY && ws_r)
        sel_r[aw_r[IDX_LSB+:IDX_W]] <= wd_r;
    end
  end

  // ----------
  // Assertions
  // ----------
  // A select held for two cycles takes the pad enable from its function's enable, one cycle late.
  property p_route(int p, logic [4:0] c, logic [5:0] f);
    sel_r[p] == c && $past(sel_r[p]) == c |->
      pin_oe[p] == $past(periph_oe[f]);
  endproperty

  for (genvar p = 0; p < NPINS; p++) begin : g_pin
    a_zero_hiz: assert property (
      sel_r[p] == SEL_HIZ && $past(sel_r[p]) == SEL_HIZ |->
        !pin_oe[p] && !pin_out[p])
      else $error("zero select drives a pad");
  end

  a_pin0_touch: assert property (
    p_route(0, SEL_TOUCH, FN_TOUCH_SENSE_32))
    else $error("pin 0 route wrong");
  a_pin1_timer: assert property (
    p_route(1, SEL_TIMER_C, FN_TIMER3_IO_B))
    else $error("pin 1 route wrong");
  a_pin2_serial: assert property (
    p_route(2, SEL_SERIAL_A, FN_SERIAL5_RECEIVE_GROUP))
    else $error("pin 2 route wrong");
  a_pin3_timer: assert property (
    p_route(3, SEL_TIMER_D, FN_TIMER5_CAPTURE_V))
    else $error("pin 3 route wrong");
  a_pin4_timer: assert property (
    p_route(4, SEL_TIMER8, FN_TIMER8_RESET_IN_0))
    else $error("pin 4 route wrong");
  a_pin5_spi: assert property (
    p_route(5, SEL_SPI, FN_SPI_CLOCK_LINE))
    else $error("pin 5 route wrong");
  a_pin6_flow: assert property (
    p_route(6, SEL_SERIAL_B, FN_SERIAL5_FLOW_GROUP))
    else $error("pin 6 route wrong");
  a_bad_code: assert property (
    sel_r[5] != SEL_SPI && sel_r[5] != SEL_TOUCH && $stable(sel_r[5])
      |-> !pin_oe[5])
    else $error("unlisted code drives pin 5");
  a_no_pin7: assert property (
    $rose(s_axi_bvalid) && aw_r[ADDR_W-1:IDX_LSB] >= 7 |->
      s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_read_unmap: assert property (
    $rose(s_axi_rvalid) && ar_r[ADDR_W-1:IDX_LSB] >= 7 |->
      s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
    else $error("unmapped read not refused");
  a_read_field: assert property (
    $rose(s_axi_rvalid) && ar_r[ADDR_W-1:IDX_LSB] < 7 |->
      s_axi_rresp == RESP_OKAY &&
      s_axi_rdata == {27'h0, sel_r[ar_r[IDX_LSB+:IDX_W]]})
    else $error("read data differs from select field");

  c_refused: cover property ($rose(s_axi_bvalid) && s_axi_bresp != 0);
  c_pin5_on: cover property (pin_oe[5]);
  c_read: cover property ($rose(s_axi_rvalid));

endmodule : pfm_mux_monitor

bind pfm_port_a_mux pfm_mux_monitor #(
  .NPINS(NPINS), .NFUNCS(NFUNCS)
) u_mon (
  .sys_clk(sys_clk), .sys_rst(sys_rst),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .periph_oe(periph_oe),
  .pin_oe(pin_oe), .pin_out(pin_out)
);

// File: bench/pfm_far_model.sv
`timescale 1ns/1ps

module pfm_far_model
  import pfm_pkg::*;
(
  input  wire logic [NUM_FUNCS-1:0] func_drv,
  input  wire logic [NUM_FUNCS-1:0] func_en,
  input  wire logic [NUM_PINS-1:0]  pad_drv,
  input  wire logic [NUM_PINS-1:0]  pin_out,
  input  wire logic [NUM_PINS-1:0]  pin_oe,
  output logic      [NUM_FUNCS-1:0] periph_out,
  output logic      [NUM_FUNCS-1:0] periph_oe,
  output logic      [NUM_PINS-1:0]  pin_in
);
  // A released function shows the inverse of its level, never a stale copy.
  assign periph_oe  = func_en;
  assign periph_out = ~(func_drv ^ func_en);
  // The pad wire: the block's drive wins, else the outside source.
  assign pin_in = (pin_out & pin_oe) | (pad_drv & ~pin_oe);
endmodule : pfm_far_model

// File: bench/tb_top.sv
`timescale 1ns/1ps

module tb_top
  import pfm_pkg::*;
;
  logic                 sys_clk = 1'b0;
  logic                 sys_rst = 1'b1;
  logic [ADDR_W-1:0]    awaddr = '0, araddr = '0;
  logic [31:0]          wdata = '0;
  logic [3:0]           wstrb = '0;
  logic                 awvalid = 0, wvalid = 0, bready = 0;
  logic                 arvalid = 0, rready = 0;
  logic                 awready, wready, bvalid, arready, rvalid;
  logic [1:0]           bresp, rresp;
  logic [31:0]          rdata;
  logic [NUM_FUNCS-1:0] drv = '1, en = '1, periph_out, periph_oe, periph_in;
  logic [NUM_PINS-1:0]  pad = '0, pin_in, pin_out, pin_oe;
  logic [11:0]          bad [3] = '{12'h01C, 12'h020, 12'h41C};
  int                   failures = 0, checks = 0;

  always #10 sys_clk = ~sys_clk;

  pfm_port_a_mux dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .periph_out(periph_out), .periph_oe(periph_oe),
    .periph_in(periph_in), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  pfm_far_model u_far (
    .func_drv(drv), .func_en(en), .pad_drv(pad), .pin_out(pin_out),
    .pin_oe(pin_oe), .periph_out(periph_out), .periph_oe(periph_oe),
    .pin_in(pin_in)
  );

  // ----------
  // Shared tasks
  // ----------
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // Ready is read at the falling edge, where it equals the next sample.
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] resp);
    logic aw, w, b;
    aw = 0;
    w = 0;
    b = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(negedge sys_clk);
      aw = awready;
      w = wready;
      b = bvalid;
      resp = bresp;
      @(posedge sys_clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] resp);
    logic ar, r;
    ar = 0;
    r = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r) begin
      @(negedge sys_clk);
      ar = arready;
      r = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge sys_clk);
      if (ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axi_rd

  task automatic settle(int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle

  // Select, check both directions of the route, then return to Hi-Z.
  task automatic route(input int p, input logic [4:0] c, input int f);
    logic [31:0] d;
    logic [1:0]  rs;
    axi_wr(12'(4 * p), {24'h0, 3'b111, c}, 4'h1, rs);
    check("wr resp", 32'(rs), 32'(RESP_OKAY));
    axi_rd(12'(4 * p), d, rs);
    check("sel read", d, {27'h0, c});
    @(posedge sys_clk);
    en <= NUM_FUNCS'(1) << f;
    drv <= NUM_FUNCS'(1) << f;
    settle(3);
    check("pin oe", 32'(pin_oe[p]), 32'h1);
    check("pin out", 32'(pin_out[p]), 32'h1);
    @(posedge sys_clk);
    en <= '0;
    pad <= NUM_PINS'(1) << p;
    settle(8);
    check("periph in", 32'(periph_in[f]), 32'h1);
    @(posedge sys_clk);
    pad <= '0;
    en <= '1;
    axi_wr(12'(4 * p), 32'h0, 4'h1, rs);
    settle(3);
    check("hiz oe", 32'(pin_oe), 32'h0);
  endtask : route

  // ----------
  // Tests
  // ----------
  initial begin
    logic [31:0] d;
    logic [1:0]  rs;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int p = 0; p < 7; p++) begin
      axi_rd(12'(4 * p), d, rs);
      check("reset sel", d, 32'h0);
    end
    check("reset oe", 32'(pin_oe), 32'h0);
    route(0, 5'h01, 6'h00); route(0, 5'h07, 6'h01);
    route(0, 5'h0D, 6'h02); route(0, 5'h19, 6'h03);
    route(1, 5'h01, 6'h04); route(1, 5'h02, 6'h05);
    route(1, 5'h03, 6'h06); route(1, 5'h0A, 6'h07);
    route(1, 5'h0D, 6'h08); route(1, 5'h19, 6'h09);
    route(2, 5'h0A, 6'h0A); route(2, 5'h0D, 6'h0B);
    route(2, 5'h19, 6'h0C);
    route(3, 5'h01, 6'h0D); route(3, 5'h02, 6'h0E);
    route(3, 5'h03, 6'h0F); route(3, 5'h04, 6'h10);
    route(3, 5'h0A, 6'h0A); route(3, 5'h19, 6'h11);
    route(4, 5'h01, 6'h12); route(4, 5'h02, 6'h13);
    route(4, 5'h03, 6'h14); route(4, 5'h05, 6'h15);
    route(4, 5'h0A, 6'h16); route(4, 5'h0D, 6'h17);
    route(4, 5'h19, 6'h18);
    route(5, 5'h0D, 6'h19); route(5, 5'h19, 6'h1A);
    route(6, 5'h01, 6'h10); route(6, 5'h02, 6'h1B);
    route(6, 5'h03, 6'h1C); route(6, 5'h05, 6'h1D);
    route(6, 5'h07, 6'h1E); route(6, 5'h0B, 6'h1F);
    route(6, 5'h0D, 6'h20); route(6, 5'h19, 6'h21);
    axi_wr(12'h008, 32'h0A, 4'h1, rs);
    axi_wr(12'h008, 32'h0D, 4'hE, rs);
    axi_rd(12'h008, d, rs);
    check("strobe off", d, 32'h0A);
    for (int c = 0; c < 32; c++) begin
      axi_wr(12'h014, 32'(c), 4'h1, rs);
      settle(3);
      check("pin5 oe", 32'(pin_oe[5]),
            32'(5'(c) == SEL_SPI || 5'(c) == SEL_TOUCH));
    end
    foreach (bad[i]) begin
      axi_wr(bad[i], 32'h19, 4'h1, rs);
      check("bad wr resp", 32'(rs), 32'(RESP_SLVERR));
      axi_rd(bad[i], d, rs);
      check("bad rd resp", 32'(rs), 32'(RESP_SLVERR));
      check("bad rd data", d, 32'h0);
    end
    axi_rd(12'h000, d, rs);
    check("pin0 kept", d, 32'h0);
    axi_wr(12'h010, 32'h19, 4'h1, rs);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    axi_rd(12'h010, d, rs);
    check("rst sel", d, 32'h0);
    check("rst oe", 32'(pin_oe), 32'h0);
    close_out();
  end

  // A hung handshake is cut short well past the expected run length.
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    close_out();
  end

endmodule : tb_top
